/* hw/sctr_pkg.sv */
package sctr_pkg;

  // timing: system clock and derived tick counts
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned MS_NS         = 1000000;
  // least time, rounded up to whole cycles
  localparam int unsigned MS_CYCLES     =
    (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0]  MS_PER_10MS   = 4'ha;
  localparam logic [9:0]  MS_PER_S      = 10'h3e8;

  // constant-scan setting limit in 10 ms units, and highest program code
  localparam logic [7:0]  CONST_MAX     = 8'hc8;
  localparam logic [3:0]  PROG_MAX      = 4'hb;

  // register word addresses
  localparam logic [3:0]  OFS_PROG      = 4'h0;
  localparam logic [3:0]  OFS_MIN       = 4'h1;
  localparam logic [3:0]  OFS_COARSE    = 4'h2;
  localparam logic [3:0]  OFS_MAX       = 4'h3;
  localparam logic [3:0]  OFS_CONST     = 4'h4;
  localparam logic [3:0]  OFS_FINE      = 4'h5;
  localparam logic [3:0]  OFS_SECONDS   = 4'h6;
  localparam logic [3:0]  OFS_YEARMON   = 4'h9;

  // values after reset
  localparam logic [15:0] RST_WORD      = 16'h0000;
  localparam logic [7:0]  RST_CONST     = 8'h00;
  localparam logic [3:0]  RST_PROG      = 4'h0;

  // scan sequencer states
  typedef enum logic [1:0] {
    ST_STOP = 2'b00,
    ST_SCAN = 2'b01,
    ST_WAIT = 2'b10
  } sctr_state_t;

  // scan-time statistics kept together
  typedef struct packed {
    logic [15:0] min_t;
    logic [15:0] max_t;
    logic [15:0] coarse;
    logic [15:0] fine;
  } sctr_stat_t;

  // live scan measurement
  typedef struct packed {
    logic [15:0] ms;
    logic [15:0] ms10;
    logic [3:0]  sub;
  } sctr_meas_t;

endpackage

/* hw/sctr_top.sv */
`timescale 1ns/1ps
// Functional notes
// - running_program_code holds 0 to B naming the program now executing.
// - at scan end, minimum_scan_time takes the 10 ms scan time if smaller.
// - at scan end, maximum_scan_time takes the 10 ms scan time if greater.
// - scan_time_coarse is loaded at every scan end in 10 ms units.
// - a constant-scan setting of zero starts each scan right after the last.
// - a setting N of 1 to 200 starts scans every N times 10 ms.
// - scan_time_fine is loaded at every scan end in 1 ms units.
// - in run, seconds_counter increments once per elapsed second.
// - seconds_counter wraps 32767 to -32768 like a 16-bit signed count.
// - clock_year_month has BCD year in bits 15:8 and BCD month in 7:0.
module sctr_top #(
  parameter int unsigned MS_CYCLES_P = sctr_pkg::MS_CYCLES
) (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  input  wire logic        run_mode,
  input  wire logic        scan_end,
  output logic             scan_start,
  input  wire logic [3:0]  prog_code,
  input  wire logic [7:0]  cal_year_bcd,
  input  wire logic [7:0]  cal_month_bcd
);

  logic [16:0]             ms_cnt;
  logic [16:0]             next_ms_cnt;
  logic                    ms_tick;
  logic [9:0]              sec_ms;
  logic [9:0]              next_sec_ms;
  logic [15:0]             seconds;
  logic [15:0]             next_seconds;
  logic                    sec_tick;
  sctr_pkg::sctr_state_t   state;
  sctr_pkg::sctr_state_t   next_state;
  sctr_pkg::sctr_meas_t    meas;
  sctr_pkg::sctr_meas_t    next_meas;
  sctr_pkg::sctr_stat_t    stat;
  sctr_pkg::sctr_stat_t    next_stat;
  logic                    first_scan;
  logic                    next_first_scan;
  logic                    next_scan_start;
  logic                    capture;
  logic [10:0]             target_ms;
  logic [7:0]              const_n;
  logic [7:0]              next_const_n;
  logic [3:0]              prog_q;
  logic [3:0]              next_prog_q;
  logic [15:0]             year_mon;
  logic [15:0]             next_year_mon;
  logic [15:0]             next_rdata;

  // free-running 1 ms prescaler; scan times land within one tick of the true time
  always_comb begin
    ms_tick = (ms_cnt == 17'(MS_CYCLES_P - 1));
    next_ms_cnt = ms_tick ? 17'h00000 : ms_cnt + 17'h00001;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ms_cnt <= 17'h00000;
    end else begin
      ms_cnt <= next_ms_cnt;
    end
  end

  // seconds in run
  // sub-second count restarts outside run so the first second is whole
  always_comb begin
    sec_tick = ms_tick && (sec_ms == sctr_pkg::MS_PER_S - 10'h001);
    next_sec_ms = sec_ms;
    next_seconds = seconds;
    if (!run_mode) begin
      next_sec_ms = 10'h000;
    end else if (ms_tick) begin
      next_sec_ms = sec_tick ? 10'h000 : sec_ms + 10'h001;
    end
    if (run_mode && sec_tick) begin
      next_seconds = seconds + 16'h0001;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sec_ms  <= 10'h000;
      seconds <= sctr_pkg::RST_WORD;
    end else begin
      sec_ms  <= next_sec_ms;
      seconds <= next_seconds;
    end
  end

  // scan sequencer with measurement counters
  // zero setting restarts at once
  // interval of N times 10 ms
  always_comb begin
    capture = (state == sctr_pkg::ST_SCAN) && run_mode && scan_end;
    target_ms = 11'(const_n) * 11'h00a;
    next_state = state;
    next_scan_start = 1'b0;
    next_first_scan = first_scan;
    next_meas = meas;
    // count ms while scanning and while waiting out the interval
    if (ms_tick) begin
      if (meas.ms != 16'hffff) begin
        next_meas.ms = meas.ms + 16'h0001;
      end
      if (meas.sub == sctr_pkg::MS_PER_10MS - 4'h1) begin
        next_meas.sub = 4'h0;
        if (meas.ms10 != 16'hffff) begin
          next_meas.ms10 = meas.ms10 + 16'h0001;
        end
      end else begin
        next_meas.sub = meas.sub + 4'h1;
      end
    end
    unique case (state)
      sctr_pkg::ST_STOP: begin
        if (run_mode) begin
          next_state = sctr_pkg::ST_SCAN;
          next_scan_start = 1'b1;
          next_first_scan = 1'b1;
        end
      end
      sctr_pkg::ST_SCAN: begin
        if (!run_mode) begin
          next_state = sctr_pkg::ST_STOP;
        end else if (scan_end) begin
          next_first_scan = 1'b0;
          if (const_n == 8'h00) begin
            next_scan_start = 1'b1;
          end else begin
            next_state = sctr_pkg::ST_WAIT;
          end
        end
      end
      sctr_pkg::ST_WAIT: begin
        if (!run_mode) begin
          next_state = sctr_pkg::ST_STOP;
        end else if (meas.ms >= 16'(target_ms)) begin
          next_state = sctr_pkg::ST_SCAN;
          next_scan_start = 1'b1;
        end
      end
      default: begin
        next_state = sctr_pkg::ST_STOP;
      end
    endcase
    if (next_scan_start) begin
      next_meas = '0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state      <= sctr_pkg::ST_STOP;
      scan_start <= 1'b0;
      first_scan <= 1'b1;
      meas       <= '0;
    end else begin
      state      <= next_state;
      scan_start <= next_scan_start;
      first_scan <= next_first_scan;
      meas       <= next_meas;
    end
  end

  // statistics captured at each scan end
  always_comb begin
    next_stat = stat;
    if (capture) begin
      next_stat.fine = meas.ms;
      next_stat.coarse = meas.ms10;
      if (first_scan || meas.ms10 < stat.min_t) begin
        next_stat.min_t = meas.ms10;
      end
      if (first_scan || meas.ms10 > stat.max_t) begin
        next_stat.max_t = meas.ms10;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stat <= '0;
    end else begin
      stat <= next_stat;
    end
  end

  // program code, calendar word and the writable interval setting
  always_comb begin
    next_prog_q = prog_q;
    // codes above B are not a program and are ignored
    if (prog_code <= sctr_pkg::PROG_MAX) begin
      next_prog_q = prog_code;
    end
    // year high byte, month low byte
    next_year_mon = {cal_year_bcd, cal_month_bcd};
    next_const_n = const_n;
    // settings above 200 saturate rather than wrap to a short interval
    if (reg_wr && reg_addr == sctr_pkg::OFS_CONST) begin
      if (reg_wdata > 16'(sctr_pkg::CONST_MAX)) begin
        next_const_n = sctr_pkg::CONST_MAX;
      end else begin
        next_const_n = reg_wdata[7:0];
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      prog_q   <= sctr_pkg::RST_PROG;
      year_mon <= sctr_pkg::RST_WORD;
      const_n  <= sctr_pkg::RST_CONST;
    end else begin
      prog_q   <= next_prog_q;
      year_mon <= next_year_mon;
      const_n  <= next_const_n;
    end
  end

  // read mux; data stands for exactly the cycle after the strobe
  always_comb begin
    next_rdata = 16'h0000;
    if (reg_rd) begin
      unique case (reg_addr)
        sctr_pkg::OFS_PROG:    next_rdata = {12'h000, prog_q};
        sctr_pkg::OFS_MIN:     next_rdata = stat.min_t;
        sctr_pkg::OFS_COARSE:  next_rdata = stat.coarse;
        sctr_pkg::OFS_MAX:     next_rdata = stat.max_t;
        sctr_pkg::OFS_CONST:   next_rdata = {8'h00, const_n};
        sctr_pkg::OFS_FINE:    next_rdata = stat.fine;
        sctr_pkg::OFS_SECONDS: next_rdata = seconds;
        sctr_pkg::OFS_YEARMON: next_rdata = year_mon;
        default:               next_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_prog_range;
    prog_q <= sctr_pkg::PROG_MAX;
  endproperty
  a_prog_range: assert property (p_prog_range)
    else $error("program code out of range");

  property p_min_upd;
    capture && !first_scan && (meas.ms10 < stat.min_t)
      |=> stat.min_t == $past(meas.ms10);
  endproperty
  a_min_upd: assert property (p_min_upd)
    else $error("minimum not updated");

  property p_max_upd;
    capture && !first_scan && (meas.ms10 > stat.max_t)
      |=> stat.max_t == $past(meas.ms10);
  endproperty
  a_max_upd: assert property (p_max_upd)
    else $error("maximum not updated");

  property p_coarse;
    capture |=> stat.coarse == $past(meas.ms10);
  endproperty
  a_coarse: assert property (p_coarse)
    else $error("coarse time not loaded");

  property p_no_const;
    capture && (const_n == 8'h00) |=> scan_start ##1 !scan_start;
  endproperty
  a_no_const: assert property (p_no_const)
    else $error("free scan did not restart at once");

  property p_const_hold;
    (state == sctr_pkg::ST_WAIT) && (meas.ms < 16'(target_ms))
      |=> !scan_start;
  endproperty
  a_const_hold: assert property (p_const_hold)
    else $error("scan started before interval");

  property p_fine;
    capture |=> stat.fine == $past(meas.ms);
  endproperty
  a_fine: assert property (p_fine)
    else $error("fine time not loaded");

  property p_sec_inc;
    run_mode && sec_tick |=> seconds == $past(seconds) + 16'h0001;
  endproperty
  a_sec_inc: assert property (p_sec_inc)
    else $error("seconds did not advance");

  property p_sec_hold;
    !sec_tick |=> $stable(seconds);
  endproperty
  a_sec_hold: assert property (p_sec_hold)
    else $error("seconds moved without a tick");

  property p_year_mon;
    ##1 year_mon == {$past(cal_year_bcd), $past(cal_month_bcd)};
  endproperty
  a_year_mon: assert property (p_year_mon)
    else $error("year/month layout wrong");

  property p_first;
    capture && first_scan |=> stat.min_t == stat.max_t;
  endproperty
  a_first: assert property (p_first)
    else $error("first scan not in both min and max");

  property p_order;
    !first_scan |-> stat.min_t <= stat.max_t;
  endproperty
  a_order: assert property (p_order)
    else $error("minimum above maximum");

  property p_meas_start;
    scan_start |-> (meas == '0);
  endproperty
  a_meas_start: assert property (p_meas_start)
    else $error("scan measurement not restarted");

endmodule // sctr_top

/* sim/sctr_tb_top.sv */
`timescale 1ns/1ps
module sctr_tb_top;
  typedef struct {
    string       nm;
    logic [15:0] lo;
    logic [15:0] hi;
  } sctr_exp_t;

  logic        clk_sys;
  logic        rst;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  logic        run_mode;
  logic        scan_end;
  logic        scan_start;
  logic [3:0]  prog_code;
  logic [7:0]  cal_year_bcd;
  logic [7:0]  cal_month_bcd;
  logic        rd_seen = 1'b0;
  int          num_errors;
  int          n_tests;
  int          cyc = 0;
  int          t_start;
  logic [31:0] seed;
  sctr_exp_t   expq[$];

  // 1 ms shrunk to 10 clocks so a second fits in the run
  sctr_top #(.MS_CYCLES_P(10)) DUT (
    .clk_sys       (clk_sys),
    .rst           (rst),
    .reg_addr      (reg_addr),
    .reg_wdata     (reg_wdata),
    .reg_wr        (reg_wr),
    .reg_rd        (reg_rd),
    .reg_rdata     (reg_rdata),
    .run_mode      (run_mode),
    .scan_end      (scan_end),
    .scan_start    (scan_start),
    .prog_code     (prog_code),
    .cal_year_bcd  (cal_year_bcd),
    .cal_month_bcd (cal_month_bcd)
  );

  always #5 clk_sys = ~clk_sys;

  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
  end

  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // range compare; an unknown word never counts as inside the range
  task automatic chk(input string nm, input logic [15:0] lo,
                     input logic [15:0] hi, input logic [15:0] got);
    logic ok;
    ok = (got >= lo) && (got <= hi);
    n_tests++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("BAD %s expected %0h..%0h seen %0h", nm, lo, hi, got);
    end
  endtask

  // read word stands only in the cycle after the strobe
  always @(posedge clk_sys) begin
    rd_seen <= reg_rd;
    if (rd_seen === 1'b1) begin
      chk(expq[0].nm, expq[0].lo, expq[0].hi, reg_rdata);
      void'(expq.pop_front());
    end
  end

  task automatic rd(input logic [3:0] a, input string nm,
                    input logic [15:0] lo, input logic [15:0] hi);
    expq.push_back('{nm, lo, hi});
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    // idle edge so a following call never re-drives the strobe at once
    @(posedge clk_sys);
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    // idle edge so a following call never re-drives the strobe at once
    @(posedge clk_sys);
  endtask

  // bounded wait so a missing start pulse cannot hang the run
  task automatic wait_start();
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (scan_start !== 1'b1 && n < 5000);
    chk("scan start", 16'h1, 16'h1, {15'h0, scan_start});
    t_start = cyc;
  endtask

  task automatic end_scan(input int len, input logic quick);
    while (cyc - t_start < len) @(posedge clk_sys);
    scan_end <= 1'b1;
    @(posedge clk_sys);
    scan_end <= 1'b0;
    if (quick) begin
      @(posedge clk_sys);
      chk("restart", 16'h1, 16'h1, {15'h0, scan_start});
      t_start = cyc;
    end
  endtask

  // fine has a 1 ms slack since the tick runs free of the scan
  task automatic stats(input logic [15:0] c, input logic [15:0] f,
                       input logic [15:0] mn, input logic [15:0] mx);
    rd(4'h2, "coarse", c, c);
    rd(4'h5, "fine", f - 16'h1, f + 16'h1);
    rd(4'h1, "minimum", mn, mn);
    rd(4'h3, "maximum", mx, mx);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk_sys);
    num_errors++;
    results();
  end

  initial begin
    logic [7:0] y;
    logic [7:0] mb;
    int         ts;
    int         t_run;
    clk_sys = 1'b0;
    rst = 1'b1;
    {reg_addr, reg_wdata, reg_wr, reg_rd, run_mode, scan_end} = '0;
    {prog_code, cal_year_bcd, cal_month_bcd} = '0;
    {num_errors, n_tests, t_start} = '0;
    seed = 32'ha42aad34;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    // every word, mapped or not, reads zero after reset
    for (int a = 0; a < 16; a++) rd(a[3:0], "reset word", 16'h0, 16'h0);
    wr(4'h1, 16'hffff);
    rd(4'h1, "read-only write", 16'h0, 16'h0);
    wr(4'h4, 16'h012c);
    rd(4'h4, "interval clamp", 16'hc8, 16'hc8);
    wr(4'h4, 16'h0000);
    rd(4'h4, "interval zero", 16'h0, 16'h0);
    $display("test registers done");
    for (int p = 0; p < 12; p++) begin
      prog_code <= p[3:0];
      @(posedge clk_sys);
      rd(4'h0, "program code", 16'(p), 16'(p));
    end
    // a code above B names no program, so the last valid code stays
    prog_code <= 4'hf;
    @(posedge clk_sys);
    rd(4'h0, "program code kept", 16'hb, 16'hb);
    // random bcd dates, month kept within 1 to 12
    for (int i = 0; i < 6; i++) begin
      seed = xs(seed);
      y = {4'(seed[3:0] % 10), 4'(seed[7:4] % 10)};
      mb = 8'(seed[11:8] % 12 + 1);
      mb = (mb < 8'h0a) ? mb : mb + 8'h06;
      cal_year_bcd <= y;
      cal_month_bcd <= mb;
      @(posedge clk_sys);
      rd(4'h9, "year month", {y, mb}, {y, mb});
    end
    $display("test identity done");
    run_mode <= 1'b1;
    t_run = cyc;
    wait_start();
    end_scan(255, 1'b1);
    stats(16'h2, 16'h19, 16'h2, 16'h2);
    end_scan(455, 1'b1);
    stats(16'h4, 16'h2d, 16'h2, 16'h4);
    end_scan(155, 1'b1);
    stats(16'h1, 16'hf, 16'h1, 16'h4);
    wr(4'h4, 16'h0003);
    end_scan(50, 1'b0);
    stats(16'h0, 16'h5, 16'h0, 16'h4);
    ts = t_start;
    wait_start();
    chk("interval", 16'h122, 16'h131, 16'(t_start - ts));
    $display("test scans done");
    while (cyc - t_run < 25000) @(posedge clk_sys);
    rd(4'h6, "seconds", 16'h2, 16'h2);
    run_mode <= 1'b0;
    repeat (12000) @(posedge clk_sys);
    rd(4'h6, "seconds held", 16'h2, 16'h2);
    rd(4'h3, "maximum held", 16'h4, 16'h4);
    @(posedge clk_sys);
    @(posedge clk_sys);
    $display("test seconds done");
    results();
  end
endmodule // sctr_tb_top
